/* flash_ctrl.sv */
/*
  Internal memory decoder with remap, embedded flash array, write buffer,
  prefetch buffer, lock regions and the key-protected command sequencer.
  Assumes the system bus master holds its request until the ready pulse,
  and an AXI4-Lite master for the user registers, all on aclk.
*/
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// How it works
// R1 - SRAM only at its window before remap
// R2 - After remap SRAM also at zero
// R3 - Flash always at its own window
// R4 - Flash at zero before remap
// R5 - Three 1-Mbyte areas in 256-Mbyte space
// R6 - Above SRAM window: no memory, abort
// R7 - 512 pages, 16384 readable words
// R8 - 128-byte write buffer, 32-bit loads
// R9 - Bus reads flash, writes buffer
// R10 - Wait states and timing programmable; here only wait states (mode[3:0]), program and erase busy counts are module parameters, NVM_CYC is fixed
// R11 - Erase, program, NVM set/clear commands
// R12 - Commands run only with correct key
// R13 - Readable command-complete status
// R14 - Readable error flags
// R15 - Separate completion and error interrupts
// R16 - Forbidden command leaves flash, flags error
// R17 - Program within 4 ms or 2 ms
// R18 - Full erase within 10 ms
// R19 - Two-word prefetch buffer
// R20 - 16 lock regions of 32 pages
// R21 - Locked region refuses erase, program
// R22 - Region is upper four page bits
module flash_ctrl #(
  parameter int PROG_AE_C = flash_pkg::PROG_AE_CYC,
  parameter int PROG_NE_C = flash_pkg::PROG_NE_CYC,
  parameter int ERASE_C = flash_pkg::ERASE_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire flash_pkg::axi_req_type axi_req,
  output flash_pkg::axi_rsp_type axi_rsp,
  // System bus
  input wire flash_pkg::sys_req_type sys_req,
  output flash_pkg::sys_rsp_type sys_rsp,
  // Interrupt request
  output logic flash_irq
);
  import flash_pkg::*;

  typedef struct packed {
    axi_rsp_type axo;
    sys_rsp_type rsp;
    logic irq;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] mode;
    logic [1:0] ien;
    logic [15:0] lock;
    logic [7:0] nvm;
    logic remap;
    logic err_lock;
    logic err_key;
    logic busy;
    logic [3:0] cmd;
    logic [13:0] base;
    logic [14:0] lim;
    logic [14:0] idx;
    logic [16:0] cnt;
    bus_state_type bs;
    logic [3:0] wcnt;
    logic pf_ok;
    logic [12:0] pf_tag;
    logic [31:0] pf0;
    logic [31:0] pf1;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  // Memories stay out of the state record: too large to reset
  logic [31:0] flash_mem [FLASH_WORDS];
  logic [31:0] sram_mem [SRAM_WORDS];
  logic [31:0] wbuf [PAGE_WORDS];

  logic flash_we;
  logic [13:0] flash_wa;
  logic [31:0] flash_wd;
  logic sram_we;
  logic wbuf_we;
  logic cmd_wr;
  logic go;
  logic [31:0] wv;
  logic [3:0] ck;
  logic [8:0] pg;
  area_type area;

  function automatic area_type decode(input logic [31:0] a, input logic rm);
    area_type r;
    r = A_NONE;
    if (a < SPACE_END) begin // R5
      if (a[27:AREA_LSB] == 8'h00) begin
        r = rm ? A_SRAM : A_FLASH; // R2 R4
      end else if (a[27:AREA_LSB] == FLASH_BASE[27:AREA_LSB]) begin
        r = A_FLASH; // R3
      end else if (a[27:AREA_LSB] == SRAM_BASE[27:AREA_LSB]) begin
        r = A_SRAM; // R1
      end
    end
    return r; // R6
  endfunction : decode

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] rd_reg(input logic [7:0] a, input state_type s);
    logic [31:0] r;
    r = 32'h0;
    unique case (a)
      OFS_MODE: r = s.mode; // R10
      OFS_STAT: r = {29'h0, s.err_key, s.err_lock, !s.busy}; // R13 R14
      OFS_IEN: r = {30'h0, s.ien};
      OFS_LOCK: r = {8'h0, s.nvm, s.lock};
      OFS_REMAP: r = {31'h0, s.remap};
      default: r = 32'h0;
    endcase
    return r;
  endfunction : rd_reg

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp.ready = 1'b0;
    st_nxt.rsp.abort = 1'b0;
    flash_we = 1'b0;
    flash_wa = 14'h0;
    flash_wd = 32'h0;
    sram_we = 1'b0;
    wbuf_we = 1'b0;
    cmd_wr = 1'b0;
    go = 1'b0;
    wv = merge(rd_reg(st_r.aw_addr, st_r), st_r.w_data, st_r.w_strb);
    ck = wv[3:0];
    pg = wv[PAGE_LSB +: 9];
    area = decode(sys_req.addr, st_r.remap);
    // Sequencer walks one word a cycle while the timing count runs down alongside
    if (st_r.busy) begin
      st_nxt.pf_ok = 1'b0;
      if (st_r.idx < st_r.lim) begin
        flash_we = 1'b1;
        flash_wa = st_r.base + st_r.idx[13:0];
        if (st_r.cmd == C_PROG) begin
          flash_wd = wbuf[st_r.idx[4:0]];
        end else if (st_r.cmd == C_PROG_NE) begin
          flash_wd = flash_mem[flash_wa] & wbuf[st_r.idx[4:0]];
        end else begin
          flash_wd = 32'hffff_ffff;
        end
        st_nxt.idx = st_r.idx + 15'h1;
      end
      if (st_r.cnt == 17'h0) begin
        st_nxt.busy = 1'b0; // R13
      end else begin
        st_nxt.cnt = st_r.cnt - 17'h1;
      end
    end
    // Register reads; status read clears errors before any new set
    if (st_r.axo.rvalid && axi_req.rready) begin
      st_nxt.axo.rvalid = 1'b0;
    end
    if (axi_req.arvalid && st_r.axo.arready) begin
      st_nxt.axo.rvalid = 1'b1;
      st_nxt.axo.rdata = rd_reg(axi_req.araddr, st_r);
      st_nxt.axo.rresp = (axi_req.araddr inside {OFS_MODE, OFS_CMD, OFS_STAT, OFS_IEN,
                          OFS_LOCK, OFS_REMAP}) ? RESP_OKAY : RESP_DECERR;
      if (axi_req.araddr == OFS_STAT) begin
        st_nxt.err_lock = 1'b0;
        st_nxt.err_key = 1'b0;
      end
    end
    // Register writes: address and data in either order
    if (st_r.axo.bvalid && axi_req.bready) begin
      st_nxt.axo.bvalid = 1'b0;
    end
    if (axi_req.awvalid && st_r.axo.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && st_r.axo.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = axi_req.wdata;
      st_nxt.w_strb = axi_req.wstrb;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.axo.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.axo.bvalid = 1'b1;
      st_nxt.axo.bresp = RESP_OKAY;
      unique case (st_r.aw_addr)
        OFS_MODE: st_nxt.mode = wv; // R10
        OFS_CMD: cmd_wr = 1'b1;
        OFS_STAT: st_nxt.axo.bresp = RESP_OKAY;
        OFS_IEN: st_nxt.ien = wv[1:0]; // R15
        OFS_LOCK: st_nxt.axo.bresp = RESP_OKAY;
        OFS_REMAP: st_nxt.remap = st_r.remap | wv[0];
        default: st_nxt.axo.bresp = RESP_DECERR;
      endcase
    end
    st_nxt.axo.awready = !st_nxt.aw_got && !st_nxt.axo.bvalid;
    st_nxt.axo.wready = !st_nxt.w_got && !st_nxt.axo.bvalid;
    st_nxt.axo.arready = !st_nxt.axo.rvalid;
    // Command start
    if (cmd_wr) begin
      if (wv[KEY_LSB +: 8] != CMD_KEY || st_r.busy) begin
        st_nxt.err_key = 1'b1; // R12
      end else if (((ck == C_PROG || ck == C_PROG_NE || ck == C_PAGE_ERASE) &&
                    st_r.lock[pg[8:5]]) || (ck == C_FULL_ERASE && |st_r.lock)) begin
        st_nxt.err_lock = 1'b1; // R16 R21 R22
      end else begin
        go = 1'b1;
        st_nxt.busy = 1'b1; // R11
        st_nxt.cmd = ck;
        st_nxt.idx = 15'h0;
        st_nxt.base = {pg, 5'h0}; // R20
        st_nxt.lim = PAGE_LIM;
        st_nxt.cnt = 17'(NVM_CYC - 1);
        unique case (ck)
          C_PROG: st_nxt.cnt = 17'(PROG_AE_C - 1); // R17
          C_PROG_NE: st_nxt.cnt = 17'(PROG_NE_C - 1); // R17
          C_PAGE_ERASE: st_nxt.cnt = 17'(PROG_NE_C - 1);
          C_FULL_ERASE: begin
            st_nxt.base = 14'h0;
            st_nxt.lim = FULL_LIM; // R7
            st_nxt.cnt = 17'(ERASE_C - 1); // R18
          end
          C_LOCK: begin
            st_nxt.lim = 15'h0;
            st_nxt.lock[pg[8:5]] = 1'b1; // R22
          end
          C_UNLOCK: begin
            st_nxt.lim = 15'h0;
            st_nxt.lock[pg[8:5]] = 1'b0;
          end
          C_NVM_SET: begin
            st_nxt.lim = 15'h0;
            st_nxt.nvm[pg[2:0]] = 1'b1;
          end
          C_NVM_CLR: begin
            st_nxt.lim = 15'h0;
            st_nxt.nvm[pg[2:0]] = 1'b0;
          end
          default: begin
            go = 1'b0;
            st_nxt.busy = 1'b0;
            st_nxt.err_key = 1'b1;
          end
        endcase
      end
    end
    // System bus side
    unique case (st_r.bs)
      S_IDLE: begin
        if (sys_req.valid && !st_r.rsp.ready) begin
          unique case (area)
            A_NONE: begin
              st_nxt.rsp.ready = 1'b1;
              st_nxt.rsp.abort = 1'b1; // R6
            end
            A_SRAM: begin
              st_nxt.rsp.ready = 1'b1;
              sram_we = sys_req.write;
              st_nxt.rsp.rdata = sram_mem[sys_req.addr[13:2]];
            end
            A_FLASH: begin
              if (sys_req.write) begin
                wbuf_we = 1'b1; // R8 R9
                st_nxt.rsp.ready = 1'b1;
              end else if (!st_r.busy) begin
                // Flash reads wait while the array is being altered
                if (st_r.pf_ok && st_r.pf_tag == sys_req.addr[15:3]) begin
                  st_nxt.rsp.ready = 1'b1; // R19
                  st_nxt.rsp.rdata = sys_req.addr[2] ? st_r.pf1 : st_r.pf0;
                end else begin
                  st_nxt.wcnt = st_r.mode[3:0]; // R10
                  st_nxt.bs = S_WAIT;
                end
              end
            end
            default: st_nxt.rsp.ready = 1'b0;
          endcase
        end
      end
      S_WAIT: begin
        if (st_r.wcnt != 4'h0) begin
          st_nxt.wcnt = st_r.wcnt - 4'h1;
        end else if (!st_r.busy) begin
          st_nxt.pf_ok = 1'b1; // R19
          st_nxt.pf_tag = sys_req.addr[15:3];
          st_nxt.pf0 = flash_mem[{sys_req.addr[15:3], 1'b0}];
          st_nxt.pf1 = flash_mem[{sys_req.addr[15:3], 1'b1}];
          st_nxt.rsp.ready = 1'b1; // R7 R9
          st_nxt.rsp.rdata = flash_mem[sys_req.addr[15:2]];
          st_nxt.bs = S_IDLE;
        end
      end
    endcase
    st_nxt.irq = (!st_nxt.busy && st_nxt.ien[0]) ||
                 ((st_nxt.err_lock || st_nxt.err_key) && st_nxt.ien[1]); // R15
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.mode <= MODE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (flash_we) begin
      flash_mem[flash_wa] <= flash_wd;
    end
    if (sram_we) begin
      sram_mem[sys_req.addr[13:2]] <= sys_req.wdata;
    end
    if (wbuf_we) begin
      wbuf[sys_req.addr[6:2]] <= sys_req.wdata;
    end
  end

  assign axi_rsp = st_r.axo;
  assign sys_rsp = st_r.rsp;
  assign flash_irq = st_r.irq;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_abort;
    st_r.bs == S_IDLE && sys_req.valid && !st_r.rsp.ready &&
    sys_req.addr >= 32'h0030_0000 |=> sys_rsp.ready && sys_rsp.abort;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort above sram"); // R6

  property p_key;
    cmd_wr && wv[KEY_LSB +: 8] != CMD_KEY && !st_r.busy |=> st_r.err_key && !st_r.busy;
  endproperty
  a_key: assert property (p_key) else $error("bad key ran"); // R12

  property p_locked;
    cmd_wr && wv[KEY_LSB +: 8] == CMD_KEY && !st_r.busy && ck == C_PROG &&
    st_r.lock[pg[8:5]] |=> st_r.err_lock && !st_r.busy;
  endproperty
  a_locked: assert property (p_locked) else $error("locked page programmed"); // R21

  property p_nowrite;
    flash_we |-> !st_r.lock[flash_wa[13:10]];
  endproperty
  a_nowrite: assert property (p_nowrite) else $error("locked region altered"); // R16

  property p_prog_time;
    go && ck == C_PROG |=> st_r.busy && st_r.cnt == 17'(PROG_AE_C - 1);
  endproperty
  a_prog_time: assert property (p_prog_time) else $error("program time wrong"); // R17

  property p_erase_time;
    go && ck == C_FULL_ERASE |=> st_r.busy && st_r.lim == FULL_LIM &&
    st_r.cnt == 17'(ERASE_C - 1);
  endproperty
  a_erase_time: assert property (p_erase_time) else $error("erase time wrong"); // R18

  property p_irq;
    !st_r.busy && st_r.ien[0] && !cmd_wr &&
    !(st_r.aw_got && st_r.w_got && !st_r.axo.bvalid && st_r.aw_addr == OFS_IEN) |=> flash_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("done interrupt missing"); // R15

  property p_pf_hit;
    st_r.bs == S_IDLE && sys_req.valid && !sys_req.write && !st_r.rsp.ready &&
    area == A_FLASH && !st_r.busy && st_r.pf_ok &&
    st_r.pf_tag == sys_req.addr[15:3] |=> sys_rsp.ready && !sys_rsp.abort;
  endproperty
  a_pf_hit: assert property (p_pf_hit) else $error("prefetch hit slow"); // R19

  property p_flash_read;
    st_r.bs == S_IDLE && sys_req.valid && !sys_req.write && !st_r.rsp.ready &&
    !st_r.busy && !cmd_wr && sys_req.addr[31:20] == 12'h001 |-> ##[1:17] sys_rsp.ready;
  endproperty
  a_flash_read: assert property (p_flash_read) else $error("flash read stuck"); // R3
endmodule : flash_ctrl

/* flash_pkg.sv */
/*
  Shared constants and carrier types for the flash controller and map decoder.
  Assumes one 10 MHz clock and a synchronous, active-low reset.
*/
package flash_pkg;
  localparam int CLK_MHZ = 10;
  localparam int PROG_AE_US = 4000;
  localparam int PROG_NE_US = 2000;
  localparam int ERASE_US = 10000;
  localparam int PROG_AE_CYC = PROG_AE_US * CLK_MHZ;
  localparam int PROG_NE_CYC = PROG_NE_US * CLK_MHZ;
  localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
  localparam int NVM_CYC = 16;
  localparam logic [31:0] FLASH_BASE = 32'h0010_0000;
  localparam logic [31:0] SRAM_BASE = 32'h0020_0000;
  localparam logic [31:0] SPACE_END = 32'h1000_0000;
  localparam int AREA_LSB = 20;
  localparam int FLASH_WORDS = 16384;
  localparam int SRAM_WORDS = 4096;
  localparam int PAGE_WORDS = 32;
  localparam logic [14:0] PAGE_LIM = 15'h0020;
  localparam logic [14:0] FULL_LIM = 15'h4000;
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_IEN = 8'h0c;
  localparam logic [7:0] OFS_LOCK = 8'h10;
  localparam logic [7:0] OFS_REMAP = 8'h14;
  localparam logic [31:0] MODE_RST = 32'h0000_0001;
  localparam int KEY_LSB = 24;
  localparam int PAGE_LSB = 8;
  localparam logic [7:0] CMD_KEY = 8'h5a;
  localparam logic [3:0] C_PROG = 4'h1;
  localparam logic [3:0] C_LOCK = 4'h2;
  localparam logic [3:0] C_PROG_NE = 4'h3;
  localparam logic [3:0] C_UNLOCK = 4'h4;
  localparam logic [3:0] C_PAGE_ERASE = 4'h5;
  localparam logic [3:0] C_FULL_ERASE = 4'h8;
  localparam logic [3:0] C_NVM_SET = 4'hb;
  localparam logic [3:0] C_NVM_CLR = 4'hd;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {A_NONE, A_FLASH, A_SRAM} area_type;
  typedef enum logic [0:0] {S_IDLE, S_WAIT} bus_state_type;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sys_req_type;

  typedef struct packed {
    logic ready;
    logic abort;
    logic [31:0] rdata;
  } sys_rsp_type;
endpackage : flash_pkg

/* sys_master.sv */
/*
  System bus master model: one word transfer at a time, held until ready.
  Assumes flash_pkg and a free-running aclk; the caller picks the idle gap.
*/
`timescale 1ns/1ps
module sys_master (
  // Clock
  input wire logic aclk,
  // System bus
  output flash_pkg::sys_req_type req,
  input wire flash_pkg::sys_rsp_type rsp
);
  import flash_pkg::*;

  initial req = '0;

  // Gap of zero still leaves one idle cycle between requests, larger gaps a slow master
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input int g, output int n);
    n = 0;
    repeat (g) @(posedge aclk);
    @(posedge aclk);
    req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    do begin
      @(posedge aclk);
      n++;
    end while (rsp.ready !== 1'b1);
    // Released lines show the inverse, never the stale request
    req <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
  endtask : xfer
endmodule : sys_master

/* test_flash_ctrl.sv */
/*
  Self-checking bench for flash_ctrl: AXI4-Lite register master, system bus
  partner, scoreboard queue. Assumes shortened busy counts set below.
*/
`timescale 1ns/1ps
module test_flash_ctrl;
  import flash_pkg::*;

  localparam int AE_T = 64;
  localparam int NE_T = 48;
  localparam int ER_T = 16400;
  localparam logic [33:0] ALL = '1;
  localparam logic [33:0] ABT = 34'h1_0000_0000;
  localparam logic [31:0] PG = FLASH_BASE + 32'h0000_ff80;

  typedef struct packed {logic [33:0] v; logic [33:0] m;} note_type;

  logic aclk = 1'b0;
  logic aresetn;
  axi_req_type areq;
  axi_rsp_type arsp;
  sys_req_type sreq;
  sys_rsp_type srsp;
  logic flash_irq;
  note_type notes[$];
  note_type nt;
  logic [33:0] got;
  logic [31:0] rd;
  logic [31:0] pg [32];
  logic [31:0] d;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  int lat;

  always #50 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  flash_ctrl #(.PROG_AE_C(AE_T), .PROG_NE_C(NE_T), .ERASE_C(ER_T)) flash_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn), .axi_req(areq), .axi_rsp(arsp),
    .sys_req(sreq), .sys_rsp(srsp), .flash_irq(flash_irq));
  sys_master sys_master_inst (.aclk(aclk), .req(sreq), .rsp(srsp));

  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp

  task automatic give_verdict();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // Results are judged here, in arrival order
  always @(posedge aclk) begin
    if (srsp.ready === 1'b1 || (arsp.rvalid === 1'b1 && areq.rready === 1'b1)) begin
      nt = notes.pop_front();
      got = (srsp.ready === 1'b1) ? {1'b0, srsp.abort, srsp.rdata} : {arsp.rresp, arsp.rdata};
      if (nt.m !== '0) cmp(got & nt.m, nt.v & nt.m);
    end
  end

  task automatic sx(input logic w, input logic [31:0] a, input logic [31:0] dd,
                    input logic [33:0] e, input logic [33:0] m);
    notes.push_back('{e, m});
    sys_master_inst.xfer(w, a, dd, $urandom_range(2), lat);
  endtask : sx

  task automatic aw(input logic [7:0] a, input logic [31:0] dd);
    @(posedge aclk);
    areq.awvalid <= 1'b1;
    areq.awaddr <= a;
    areq.wvalid <= 1'b1;
    areq.wdata <= dd;
    areq.wstrb <= 4'hf;
    areq.bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arsp.awready === 1'b1) areq.awvalid <= 1'b0;
      if (arsp.wready === 1'b1) areq.wvalid <= 1'b0;
    end while (arsp.bvalid !== 1'b1);
    cmp(34'(arsp.bresp), 34'((a inside {OFS_MODE, OFS_CMD, OFS_STAT, OFS_IEN, OFS_LOCK,
        OFS_REMAP}) ? RESP_OKAY : RESP_DECERR));
    areq.bready <= 1'b0;
  endtask : aw

  task automatic ar(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
    notes.push_back('{e, m});
    @(posedge aclk);
    areq.arvalid <= 1'b1;
    areq.araddr <= a;
    areq.rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arsp.arready === 1'b1) areq.arvalid <= 1'b0;
    end while (arsp.rvalid !== 1'b1);
    rd = arsp.rdata;
    areq.rready <= 1'b0;
  endtask : ar

  // Start a keyed command, poll until idle, bound the busy time
  task automatic run(input logic [3:0] c, input logic [8:0] p, input int t);
    int t0;
    int e;
    aw(OFS_CMD, {CMD_KEY, 7'h0, p, 4'h0, c});
    t0 = cyc;
    do ar(OFS_STAT, '0, '0); while (rd[0] !== 1'b1);
    e = cyc - t0;
    cmp(34'(e <= t + 8 && e + 4 >= t), 34'h1);
  endtask : run

  task automatic fill();
    for (int i = 0; i < 32; i++) begin
      pg[i] = $urandom;
      sx(1'b1, PG + 32'(i * 4), pg[i], '0, ABT);
    end
  endtask : fill

  task automatic look(input logic [31:0] b);
    for (int i = 0; i < 32; i++) sx(1'b0, b + 32'(i * 4), '0, {2'h0, pg[i]}, ALL);
  endtask : look

  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    give_verdict();
  end

  initial begin
    void'($urandom(10841));
    aresetn = 1'b0;
    areq = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    ar(OFS_MODE, {2'h0, MODE_RST}, ALL);
    ar(OFS_STAT, 34'h1, ALL);
    ar(OFS_LOCK, 34'h0, ALL);
    ar(8'h18, {RESP_DECERR, 32'h0}, 34'h3_0000_0000);
    aw(8'h18, 32'h1);
    run(C_FULL_ERASE, 9'h0, ER_T);
    aw(OFS_MODE, 32'h3);
    ar(OFS_MODE, 34'h3, ALL);
    fill();
    run(C_PROG_NE, 9'h1ff, NE_T);
    sx(1'b0, PG, '0, {2'h0, pg[0]}, ALL);
    cmp(34'(lat), 34'd6);
    look(PG);
    look(32'h0000_ff80);
    // Wrong key: refused, flash untouched
    aw(OFS_IEN, 32'h2);
    aw(OFS_CMD, {8'h00, 7'h0, 9'h1ff, 4'h0, C_PAGE_ERASE});
    repeat (2) @(posedge aclk);
    cmp(34'(flash_irq), 34'h1);
    ar(OFS_STAT, 34'h5, ALL);
    ar(OFS_STAT, 34'h1, ALL);
    // Unknown command code is refused like a bad key
    aw(OFS_CMD, {CMD_KEY, 7'h0, 9'h0, 4'h0, 4'h7});
    ar(OFS_STAT, 34'h5, ALL);
    repeat (2) @(posedge aclk);
    cmp(34'(flash_irq), 34'h0);
    sx(1'b0, PG + 32'h4, '0, {2'h0, pg[1]}, ALL);
    // Lock region 15 through its first page
    run(C_LOCK, 9'h1e0, 16);
    ar(OFS_LOCK, 34'h8000, ALL);
    aw(OFS_CMD, {CMD_KEY, 7'h0, 9'h1ff, 4'h0, C_PROG});
    cmp(34'(flash_irq), 34'h1);
    ar(OFS_STAT, 34'h3, ALL);
    sx(1'b0, PG + 32'h8, '0, {2'h0, pg[2]}, ALL);
    run(C_UNLOCK, 9'h1ff, 16);
    ar(OFS_LOCK, 34'h0, ALL);
    run(C_NVM_SET, 9'h5, 16);
    ar(OFS_LOCK, 34'h20_0000, ALL);
    run(C_NVM_CLR, 9'h5, 16);
    ar(OFS_LOCK, 34'h0, ALL);
    aw(OFS_IEN, 32'h1);
    fill();
    run(C_PROG, 9'h1ff, AE_T);
    repeat (2) @(posedge aclk);
    cmp(34'(flash_irq), 34'h1);
    look(PG);
    run(C_PAGE_ERASE, 9'h1ff, NE_T);
    sx(1'b0, PG + 32'h7c, '0, {2'h0, 32'hffff_ffff}, ALL);
    // Map before and after remap
    d = $urandom;
    sx(1'b1, SRAM_BASE + 32'h10, d, '0, ABT);
    sx(1'b0, SRAM_BASE + 32'h10, '0, {2'h0, d}, ALL);
    sx(1'b0, 32'h10, '0, {2'h0, 32'hffff_ffff}, ALL);
    aw(OFS_REMAP, 32'h1);
    sx(1'b0, 32'h10, '0, {2'h0, d}, ALL);
    sx(1'b0, FLASH_BASE + 32'h10, '0, {2'h0, 32'hffff_ffff}, ALL);
    sx(1'b0, 32'h001f_0010, '0, {2'h0, 32'hffff_ffff}, ALL);
    sx(1'b0, 32'h002f_c010, '0, {2'h0, d}, ALL);
    sx(1'b0, 32'h0030_0000, '0, ABT, ABT);
    sx(1'b1, 32'h0040_0000 + $urandom_range(32'h0fbf_fffc), d, ABT, ABT);
    sx(1'b0, 32'h1000_0000, '0, ABT, ABT);
    repeat (4) @(posedge aclk);
    give_verdict();
  end
endmodule : test_flash_ctrl
